/* src/ppd_register_decode.sv */
// Parallel port register decode behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "ppd_defines.svh"

module ppd_register_decode (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] portBase,
  input wire ppd_pkg::ppd_axi_req_s axiReq,
  output ppd_pkg::ppd_axi_rsp_s axiRsp,
  input wire logic [7:0] statusIn,
  input wire logic fifoFull,
  input wire logic fifoEmpty,
  input wire logic fifoTag,
  input wire logic irqValue,
  input wire logic [7:0] sideRdData,
  output ppd_pkg::ppd_side_s sideAcc,
  output ppd_pkg::ppd_port_s portOut,
  output ppd_pkg::ppd_l2_t l2Regs
);

  ppd_pkg::ppd_state_s st;
  ppd_pkg::ppd_state_s nxt_st;

  ppd_pkg::ppd_mode_e mode;
  ppd_pkg::ppd_reg_e wrSel;
  ppd_pkg::ppd_reg_e rdSel;
  logic aligned;
  logic doWrite;
  logic laneOk;
  logic arFire;
  logic awFire;
  logic wFire;
  logic l2Wr;
  logic l2Hit;
  logic [7:0] l2RdData;
  logic [7:0] wrByte;
  logic [7:0] rdByte;
  logic [7:0] cfgA;
  logic [7:0] cfgB;
  logic [7:0] rescfg;
  logic freeze;

  // Address decode shared by the read and the write channel
  function automatic ppd_pkg::ppd_reg_e decodeReg(
    input logic [`PPD_ADDR_W-1:0] addr,
    input ppd_pkg::ppd_mode_e md,
    input logic al
  );
    logic [`PPD_IDX_W-1:0] idx;
    idx = addr[`PPD_ADDR_W-1:`PPD_IDX_LSB];
    decodeReg = ppd_pkg::PPD_REG_BAD;
    case (idx)
      `PPD_IDX_DATA: begin
        if (md == ppd_pkg::PPD_MODE_COMPAT ||
            md == ppd_pkg::PPD_MODE_BIDIR) begin
          decodeReg = ppd_pkg::PPD_REG_DATA;
        end else if (md == ppd_pkg::PPD_MODE_ECP) begin
          decodeReg = ppd_pkg::PPD_REG_AQ;
        end else begin
          decodeReg = ppd_pkg::PPD_REG_NONE;
        end
      end
      `PPD_IDX_STATUS: decodeReg = ppd_pkg::PPD_REG_STATUS;
      `PPD_IDX_CTRL: decodeReg = ppd_pkg::PPD_REG_CTRL;
      `PPD_IDX_EPPADDR: begin
        if (md == ppd_pkg::PPD_MODE_EPP && al) begin
          decodeReg = ppd_pkg::PPD_REG_EPPADDR;
        end else begin
          decodeReg = ppd_pkg::PPD_REG_NONE;
        end
      end
      `PPD_IDX_EPP0,
      `PPD_IDX_EPP1,
      `PPD_IDX_EPP2,
      `PPD_IDX_EPP3: begin
        if (md == ppd_pkg::PPD_MODE_EPP && al) begin
          decodeReg = ppd_pkg::PPD_REG_EPPDATA;
        end else begin
          decodeReg = ppd_pkg::PPD_REG_NONE;
        end
      end
      `PPD_IDX_QUEUE: begin
        unique case (md)
          ppd_pkg::PPD_MODE_FIFO: decodeReg = ppd_pkg::PPD_REG_CQ;
          ppd_pkg::PPD_MODE_ECP: decodeReg = ppd_pkg::PPD_REG_EQ;
          ppd_pkg::PPD_MODE_TEST: decodeReg = ppd_pkg::PPD_REG_TQ;
          ppd_pkg::PPD_MODE_CFG: decodeReg = ppd_pkg::PPD_REG_CFGA;
          ppd_pkg::PPD_MODE_COMPAT,
          ppd_pkg::PPD_MODE_BIDIR,
          ppd_pkg::PPD_MODE_EPP,
          ppd_pkg::PPD_MODE_RSVD: decodeReg = ppd_pkg::PPD_REG_NONE;
        endcase
      end
      `PPD_IDX_CFGB: begin
        if (md == ppd_pkg::PPD_MODE_CFG) begin
          decodeReg = ppd_pkg::PPD_REG_CFGB;
        end else begin
          decodeReg = ppd_pkg::PPD_REG_NONE;
        end
      end
      `PPD_IDX_ECR: decodeReg = ppd_pkg::PPD_REG_ECR;
      `PPD_IDX_EIR: begin
        decodeReg = al ? ppd_pkg::PPD_REG_EIR : ppd_pkg::PPD_REG_NONE;
      end
      `PPD_IDX_EDR: begin
        decodeReg = al ? ppd_pkg::PPD_REG_EDR : ppd_pkg::PPD_REG_NONE;
      end
      `PPD_IDX_EAR: decodeReg = ppd_pkg::PPD_REG_EAR;
      default: decodeReg = ppd_pkg::PPD_REG_BAD;
    endcase
  endfunction

  // The mode field drives every shared offset; code 101 selects nothing
  assign mode = ppd_pkg::ppd_mode_e'(
    st.extended_mode_control[`PPD_ECR_MODE_HI:`PPD_ECR_MODE_LO]);
  assign aligned = (portBase[`PPD_ALIGN_W-1:0] == '0);

  assign awFire = axiReq.awvalid && !st.awHeld && !st.bValid && ce;
  assign wFire = axiReq.wvalid && !st.wHeld && !st.bValid && ce;
  assign arFire = axiReq.arvalid && !st.rValid && ce;
  assign doWrite = st.awHeld && st.wHeld && !st.bValid && ce;
  assign laneOk = st.wStrb[0];
  assign wrByte = st.wData[7:0];

  assign wrSel = decodeReg(st.awAddr, mode, aligned);
  assign rdSel = decodeReg(axiReq.araddr, mode, aligned);

  assign rescfg = l2Regs[`PPD_SLOT_RESCFG];
  assign freeze = l2Regs[`PPD_SLOT_CTRL0][`PPD_C0_FREEZE_BIT];

  assign cfgA = {4'h0, rescfg[`PPD_CFG0_CFGA_BIT], 3'h0};
  assign cfgB = {1'b0, irqValue,
                 rescfg[`PPD_CFG0_IRQ_HI:`PPD_CFG0_IRQ_LO],
                 1'b0,
                 rescfg[`PPD_CFG0_DMA_HI:`PPD_CFG0_DMA_LO]};

  // A window write that lands on an empty slot is dropped by the slot logic
  assign l2Wr = doWrite && laneOk &&
                (wrSel == ppd_pkg::PPD_REG_EDR);

  ppd_level2_regs uL2 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wrEn(l2Wr),
    .offset(st.index[`PPD_L2_OFS_W-1:0]),
    .wrData(wrByte),
    .hit(l2Hit),
    .rdData(l2RdData),
    .regs(l2Regs)
  );

  // Read mux: write-only and deselected registers read back as zero
  always_comb begin
    rdByte = `PPD_RST_BYTE;
    unique case (rdSel)
      ppd_pkg::PPD_REG_DATA: rdByte = st.dataLatch;
      ppd_pkg::PPD_REG_STATUS: rdByte = statusIn;
      ppd_pkg::PPD_REG_CTRL: rdByte = st.control;
      ppd_pkg::PPD_REG_EPPADDR: rdByte = st.eppTarget;
      ppd_pkg::PPD_REG_EPPDATA: rdByte = sideRdData;
      ppd_pkg::PPD_REG_EQ: rdByte = sideRdData;
      ppd_pkg::PPD_REG_TQ: rdByte = sideRdData;
      ppd_pkg::PPD_REG_CFGA: rdByte = cfgA;
      ppd_pkg::PPD_REG_CFGB: rdByte = cfgB;
      ppd_pkg::PPD_REG_ECR: begin
        rdByte = {st.extended_mode_control[7:`PPD_ECR_RW_LO], fifoFull, fifoEmpty};
      end
      ppd_pkg::PPD_REG_EIR: rdByte = st.index;
      ppd_pkg::PPD_REG_EDR: rdByte = l2Hit ? l2RdData : `PPD_RST_BYTE;
      ppd_pkg::PPD_REG_EAR: rdByte = {fifoTag, 7'h00};
      ppd_pkg::PPD_REG_NONE,
      ppd_pkg::PPD_REG_BAD,
      ppd_pkg::PPD_REG_AQ,
      ppd_pkg::PPD_REG_CQ: rdByte = `PPD_RST_BYTE;
    endcase
  end

  // Next state of the bus slave and of the first-level registers
  always_comb begin
    nxt_st = st;

    if (awFire) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = axiReq.awaddr;
    end
    if (wFire) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = axiReq.wdata;
      nxt_st.wStrb = axiReq.wstrb;
    end

    if (doWrite) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp = (wrSel == ppd_pkg::PPD_REG_BAD) ?
                     `PPD_RESP_DECERR : `PPD_RESP_OKAY;
      if (laneOk) begin
        unique case (wrSel)
          ppd_pkg::PPD_REG_DATA: nxt_st.dataLatch = wrByte;
          ppd_pkg::PPD_REG_CTRL: begin
            // Frozen control keeps the lines steady across a driver swap
            if (!freeze) begin
              nxt_st.control = wrByte;
            end
          end
          ppd_pkg::PPD_REG_EPPADDR: nxt_st.eppTarget = wrByte;
          ppd_pkg::PPD_REG_ECR: nxt_st.extended_mode_control = wrByte;
          ppd_pkg::PPD_REG_EIR: nxt_st.index = wrByte;
          ppd_pkg::PPD_REG_NONE,
          ppd_pkg::PPD_REG_BAD,
          ppd_pkg::PPD_REG_AQ,
          ppd_pkg::PPD_REG_STATUS,
          ppd_pkg::PPD_REG_EPPDATA,
          ppd_pkg::PPD_REG_CQ,
          ppd_pkg::PPD_REG_EQ,
          ppd_pkg::PPD_REG_TQ,
          ppd_pkg::PPD_REG_CFGA,
          ppd_pkg::PPD_REG_CFGB,
          ppd_pkg::PPD_REG_EDR,
          ppd_pkg::PPD_REG_EAR: nxt_st.index = st.index;
        endcase
      end
    end

    if (st.bValid && axiReq.bready && ce) begin
      nxt_st.bValid = 1'b0;
    end

    if (arFire) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rData = {24'h00_0000, rdByte};
      nxt_st.rResp = (rdSel == ppd_pkg::PPD_REG_BAD) ?
                     `PPD_RESP_DECERR : `PPD_RESP_OKAY;
    end else if (st.rValid && axiReq.rready && ce) begin
      nxt_st.rValid = 1'b0;
    end
  end

  // Pushes and pops toward the queue and EPP engines outside this block
  always_comb begin
    sideAcc = '0;
    sideAcc.wrData = wrByte;
    sideAcc.wrTarget = wrSel;
    sideAcc.wrPort = st.awAddr[`PPD_IDX_LSB+1:`PPD_IDX_LSB];
    sideAcc.rdTarget = rdSel;
    sideAcc.rdPort = axiReq.araddr[`PPD_IDX_LSB+1:`PPD_IDX_LSB];
    if (doWrite && laneOk) begin
      unique case (wrSel)
        ppd_pkg::PPD_REG_AQ,
        ppd_pkg::PPD_REG_CQ,
        ppd_pkg::PPD_REG_EQ,
        ppd_pkg::PPD_REG_TQ,
        ppd_pkg::PPD_REG_EPPADDR,
        ppd_pkg::PPD_REG_EPPDATA: sideAcc.wrStb = 1'b1;
        ppd_pkg::PPD_REG_NONE,
        ppd_pkg::PPD_REG_BAD,
        ppd_pkg::PPD_REG_DATA,
        ppd_pkg::PPD_REG_STATUS,
        ppd_pkg::PPD_REG_CTRL,
        ppd_pkg::PPD_REG_CFGA,
        ppd_pkg::PPD_REG_CFGB,
        ppd_pkg::PPD_REG_ECR,
        ppd_pkg::PPD_REG_EIR,
        ppd_pkg::PPD_REG_EDR,
        ppd_pkg::PPD_REG_EAR: sideAcc.wrStb = 1'b0;
      endcase
    end
    // A pop consumes data, so it fires only on the accepted read
    if (arFire) begin
      sideAcc.rdStb = (rdSel == ppd_pkg::PPD_REG_EPPDATA) ||
                      (rdSel == ppd_pkg::PPD_REG_EQ) ||
                      (rdSel == ppd_pkg::PPD_REG_TQ);
    end
  end

  always_comb begin
    axiRsp.awready = !st.awHeld && !st.bValid && ce;
    axiRsp.wready = !st.wHeld && !st.bValid && ce;
    axiRsp.bvalid = st.bValid;
    axiRsp.bresp = st.bResp;
    axiRsp.arready = !st.rValid && ce;
    axiRsp.rvalid = st.rValid;
    axiRsp.rdata = st.rData;
    axiRsp.rresp = st.rResp;
  end

  assign portOut.dataLatch = st.dataLatch;
  assign portOut.control = st.control;
  assign portOut.eppTarget = st.eppTarget;
  assign portOut.mode = mode;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.awHeld <= 1'b0;
      st.awAddr <= '0;
      st.wHeld <= 1'b0;
      st.wData <= `PPD_RST_WORD;
      st.wStrb <= 4'h0;
      st.bValid <= 1'b0;
      st.bResp <= `PPD_RESP_OKAY;
      st.rValid <= 1'b0;
      st.rData <= `PPD_RST_WORD;
      st.rResp <= `PPD_RESP_OKAY;
      st.dataLatch <= `PPD_RST_BYTE;
      st.control <= `PPD_RST_BYTE;
      st.eppTarget <= `PPD_RST_BYTE;
      st.extended_mode_control <= `PPD_RST_BYTE;
      st.index <= `PPD_RST_BYTE;
    end else if (ce) begin
      st <= nxt_st;
    end
  end

endmodule
`default_nettype wire

/* src/ppd_defines.svh */
// Offsets, field positions, reset values and bus codes of the port decode
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH

`define PPD_ADDR_W 13
`define PPD_IDX_W 11
`define PPD_IDX_LSB 2

`define PPD_IDX_DATA 11'h000
`define PPD_IDX_STATUS 11'h001
`define PPD_IDX_CTRL 11'h002
`define PPD_IDX_EPPADDR 11'h003
`define PPD_IDX_EPP0 11'h004
`define PPD_IDX_EPP1 11'h005
`define PPD_IDX_EPP2 11'h006
`define PPD_IDX_EPP3 11'h007
`define PPD_IDX_QUEUE 11'h400
`define PPD_IDX_CFGB 11'h401
`define PPD_IDX_ECR 11'h402
`define PPD_IDX_EIR 11'h403
`define PPD_IDX_EDR 11'h404
`define PPD_IDX_EAR 11'h405

`define PPD_L2_COUNT 4
`define PPD_L2_OFS_W 3
`define PPD_L2_CTRL0 3'h0
`define PPD_L2_CTRL2 3'h2
`define PPD_L2_CTRL4 3'h4
`define PPD_L2_RESCFG 3'h5
`define PPD_SLOT_CTRL0 0
`define PPD_SLOT_CTRL2 1
`define PPD_SLOT_CTRL4 2
`define PPD_SLOT_RESCFG 3

`define PPD_ALIGN_W 3
`define PPD_ECR_MODE_HI 7
`define PPD_ECR_MODE_LO 5
`define PPD_ECR_RW_LO 2
`define PPD_C0_FREEZE_BIT 5
`define PPD_CFG0_CFGA_BIT 7
`define PPD_CFG0_IRQ_HI 5
`define PPD_CFG0_IRQ_LO 3
`define PPD_CFG0_DMA_HI 1
`define PPD_CFG0_DMA_LO 0

`define PPD_RST_BYTE 8'h00
`define PPD_RST_WORD 32'h0000_0000
`define PPD_RESP_OKAY 2'h0
`define PPD_RESP_DECERR 2'h3

`endif

/* src/ppd_pkg.sv */
// Types shared by the parallel port register decode
package ppd_pkg;

  typedef enum logic [2:0] {
    PPD_MODE_COMPAT = 3'h0,
    PPD_MODE_BIDIR = 3'h1,
    PPD_MODE_FIFO = 3'h2,
    PPD_MODE_ECP = 3'h3,
    PPD_MODE_EPP = 3'h4,
    PPD_MODE_RSVD = 3'h5,
    PPD_MODE_TEST = 3'h6,
    PPD_MODE_CFG = 3'h7
  } ppd_mode_e;

  typedef enum logic [4:0] {
    PPD_REG_NONE, PPD_REG_BAD, PPD_REG_DATA, PPD_REG_AQ, PPD_REG_STATUS,
    PPD_REG_CTRL, PPD_REG_EPPADDR, PPD_REG_EPPDATA, PPD_REG_CQ,
    PPD_REG_EQ, PPD_REG_TQ, PPD_REG_CFGA, PPD_REG_CFGB, PPD_REG_ECR,
    PPD_REG_EIR, PPD_REG_EDR, PPD_REG_EAR
  } ppd_reg_e;

  typedef logic [3:0][7:0] ppd_l2_t;

  typedef struct packed {
    logic [12:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [12:0] araddr;
    logic arvalid;
    logic rready;
  } ppd_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppd_axi_rsp_s;

  typedef struct packed {
    logic wrStb;
    ppd_reg_e wrTarget;
    logic [1:0] wrPort;
    logic [7:0] wrData;
    logic rdStb;
    ppd_reg_e rdTarget;
    logic [1:0] rdPort;
  } ppd_side_s;

  typedef struct packed {
    logic [7:0] dataLatch;
    logic [7:0] control;
    logic [7:0] eppTarget;
    ppd_mode_e mode;
  } ppd_port_s;

  typedef struct packed {
    logic awHeld;
    logic [12:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] dataLatch;
    logic [7:0] control;
    logic [7:0] eppTarget;
    logic [7:0] extended_mode_control;
    logic [7:0] index;
  } ppd_state_s;

endpackage

/* src/ppd_level2_regs.sv */
// Second-level registers reached through the extended index and window
`timescale 1ns/100ps
`default_nettype none
`include "ppd_defines.svh"

module ppd_level2_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [`PPD_L2_OFS_W-1:0] offset,
  input wire logic [7:0] wrData,
  output logic hit,
  output logic [7:0] rdData,
  output ppd_pkg::ppd_l2_t regs
);

  localparam logic [`PPD_L2_COUNT-1:0][`PPD_L2_OFS_W-1:0] SLOT_OFS = {
    `PPD_L2_RESCFG, `PPD_L2_CTRL4, `PPD_L2_CTRL2, `PPD_L2_CTRL0
  };

  ppd_pkg::ppd_l2_t st;
  ppd_pkg::ppd_l2_t nxt_st;
  logic [`PPD_L2_COUNT-1:0] match;

  genvar g;
  generate
    for (g = 0; g < `PPD_L2_COUNT; g++) begin : gSlot
      assign match[g] = (offset == SLOT_OFS[g]);
    end
  endgenerate

  always_comb begin
    nxt_st = st;
    rdData = `PPD_RST_BYTE;
    for (int i = 0; i < `PPD_L2_COUNT; i++) begin
      if (match[i]) begin
        rdData = st[i];
        if (wrEn) begin
          nxt_st[i] = wrData;
        end
      end
    end
  end

  // Offsets with no slot neither store nor answer
  assign hit = |match;
  assign regs = st;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt_st;
    end
  end

endmodule
`default_nettype wire

/* verification/ppd_decode_properties.sv */
// Concurrent checks on the port decode's top-level ports
`timescale 1ns/100ps
`default_nettype none
module ppd_decode_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] portBase,
  input wire ppd_pkg::ppd_axi_req_s axiReq,
  input wire ppd_pkg::ppd_axi_rsp_s axiRsp,
  input wire ppd_pkg::ppd_side_s sideAcc,
  input wire ppd_pkg::ppd_port_s portOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_latency: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid &&
    axiRsp.rdata[31:8] == 24'h00_0000) else $error("read answer late");
  a_read_hold: assert property (
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid &&
    $stable(axiRsp.rdata)) else $error("read data dropped");
  a_write_hold: assert property (
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid &&
    $stable(axiRsp.bresp)) else $error("write response dropped");
  a_one_read: assert property (
    axiRsp.rvalid |-> !axiRsp.arready) else $error("second read taken");
  a_ce_freeze: assert property (
    !ce |-> !(axiRsp.awready || axiRsp.wready || axiRsp.arready ||
    sideAcc.wrStb || sideAcc.rdStb)) else $error("activity while frozen");
  a_push_answer: assert property (
    sideAcc.wrStb |=> axiRsp.bvalid) else $error("push without response");
  a_epp_gate: assert property (
    (sideAcc.wrStb && sideAcc.wrTarget == ppd_pkg::PPD_REG_EPPDATA) ||
    (sideAcc.rdStb && sideAcc.rdTarget == ppd_pkg::PPD_REG_EPPDATA) |->
    portBase[2:0] == 3'h0 && portOut.mode == ppd_pkg::PPD_MODE_EPP)
    else $error("data port reached outside its mode");
  a_ecp_pop: assert property (
    sideAcc.rdStb && sideAcc.rdTarget == ppd_pkg::PPD_REG_EQ |->
    portOut.mode == ppd_pkg::PPD_MODE_ECP) else $error("bad data queue pop");
  a_test_pop: assert property (
    sideAcc.rdStb && sideAcc.rdTarget == ppd_pkg::PPD_REG_TQ |->
    portOut.mode == ppd_pkg::PPD_MODE_TEST) else $error("bad test queue pop");
endmodule
`default_nettype wire

/* verification/ppd_peer_model.sv */
// Behavioural peripheral on the decode's side interface
`timescale 1ns/100ps
`default_nettype none
module ppd_peer_model #(
  parameter logic [7:0] STATUS_VALUE = 8'h3C
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ppd_pkg::ppd_side_s sideAcc,
  output logic [7:0] sideRdData,
  output logic [7:0] statusIn,
  output logic fifoFull,
  output logic fifoEmpty,
  output logic fifoTag
);
  logic [7:0] lastByte;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lastByte <= 8'h00;
    end else if (sideAcc.wrStb) begin
      lastByte <= sideAcc.wrData;
    end
  end
  // Inverse outside a pop so stale data never passes for an answer
  always_comb begin
    sideRdData = ~lastByte;
    if (sideAcc.rdStb) begin
      sideRdData = lastByte;
      if (sideAcc.rdTarget == ppd_pkg::PPD_REG_EPPDATA) begin
        sideRdData = lastByte + {6'h00, sideAcc.rdPort};
      end
    end
  end
  assign statusIn = STATUS_VALUE;
  assign fifoFull = lastByte[7];
  assign fifoEmpty = lastByte == 8'h00;
  assign fifoTag = lastByte[0];
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the port register decode
`timescale 1ns/100ps
`default_nettype none
`include "ppd_defines.svh"
module tb;
  localparam logic [7:0] STAT = 8'h3C;
  logic ref_clk, rst, ce, fifoFull, fifoEmpty, fifoTag, irqValue;
  logic [15:0] portBase;
  logic [7:0] statusIn, sideRdData;
  logic [1:0] r;
  logic [31:0] d;
  ppd_pkg::ppd_axi_req_s axiReq;
  ppd_pkg::ppd_axi_rsp_s axiRsp;
  ppd_pkg::ppd_side_s sideAcc;
  ppd_pkg::ppd_port_s portOut;
  ppd_pkg::ppd_l2_t l2Regs;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i;
  logic [2:0] l2Ofs [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h1};
  logic [7:0] l2Val [5] = '{8'h12, 8'h34, 8'h56, 8'hAB, 8'hFF};
  ppd_register_decode dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .portBase(portBase), .axiReq(axiReq), .axiRsp(axiRsp),
    .statusIn(statusIn), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty),
    .fifoTag(fifoTag), .irqValue(irqValue), .sideRdData(sideRdData),
    .sideAcc(sideAcc), .portOut(portOut), .l2Regs(l2Regs));
  ppd_peer_model #(.STATUS_VALUE(STAT)) peer (.ref_clk(ref_clk),
    .rst(rst), .sideAcc(sideAcc), .sideRdData(sideRdData),
    .statusIn(statusIn), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty),
    .fifoTag(fifoTag));
  always #12.5 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] idx, input logic [7:0] v,
                    output logic [1:0] rsp);
    logic a, w, b;
    @(posedge ref_clk);
    axiReq.awaddr <= {idx, 2'b00};
    axiReq.awvalid <= 1'b1;
    axiReq.wdata <= {24'h00_0000, v};
    axiReq.wstrb <= 4'hF;
    axiReq.wvalid <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    b = 1'b0;
    while (!(a && w)) begin
      @(negedge ref_clk);
      a = a || (axiReq.awvalid && axiRsp.awready);
      w = w || (axiReq.wvalid && axiRsp.wready);
      @(posedge ref_clk);
      if (a) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
    end
    // Late ready leaves the response waiting so its hold is exercised
    repeat (2) @(posedge ref_clk);
    axiReq.bready <= 1'b1;
    while (!b) begin
      @(negedge ref_clk);
      b = axiRsp.bvalid;
      rsp = axiRsp.bresp;
      @(posedge ref_clk);
    end
    axiReq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] idx, output logic [31:0] dat,
                    output logic [1:0] rsp);
    logic hs;
    @(posedge ref_clk);
    axiReq.araddr <= {idx, 2'b00};
    axiReq.arvalid <= 1'b1;
    hs = 1'b0;
    while (!hs) begin
      @(negedge ref_clk);
      hs = axiRsp.arready;
      @(posedge ref_clk);
    end
    axiReq.arvalid <= 1'b0;
    // Late ready leaves the read data waiting so its hold is exercised
    @(posedge ref_clk);
    axiReq.rready <= 1'b1;
    hs = 1'b0;
    while (!hs) begin
      @(negedge ref_clk);
      hs = axiRsp.rvalid;
      dat = axiRsp.rdata;
      rsp = axiRsp.rresp;
      @(posedge ref_clk);
    end
    axiReq.rready <= 1'b0;
  endtask
  task automatic wc(input logic [10:0] idx, input logic [7:0] v);
    logic [1:0] rsp;
    wr(idx, v, rsp);
    check($sformatf("bresp %h", idx), rsp, `PPD_RESP_OKAY);
  endtask
  task automatic rc(input logic [10:0] idx, input logic [7:0] exp);
    logic [31:0] dat;
    logic [1:0] rsp;
    rd(idx, dat, rsp);
    check($sformatf("rdata %h", idx), dat, {24'h00_0000, exp});
    check($sformatf("rresp %h", idx), rsp, `PPD_RESP_OKAY);
  endtask
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b0;
    irqValue = 1'b1;
    portBase = 16'h0378;
    axiReq = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    // Held frozen a little past reset so the enable gating is exercised
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    rc(`PPD_IDX_ECR, 8'h01);
    rc(`PPD_IDX_STATUS, STAT);
    wc(`PPD_IDX_DATA, 8'hA5);
    rc(`PPD_IDX_DATA, 8'hA5);
    wc(`PPD_IDX_CTRL, 8'h0C);
    rc(`PPD_IDX_CTRL, 8'h0C);
    check("control", portOut.control, 8'h0C);
    for (i = 0; i < 5; i++) begin
      wc(`PPD_IDX_EIR, {5'h00, l2Ofs[i]});
      wc(`PPD_IDX_EDR, l2Val[i]);
    end
    for (i = 0; i < 5; i++) begin
      wc(`PPD_IDX_EIR, {5'h00, l2Ofs[i]});
      rc(`PPD_IDX_EDR, (i == 4) ? 8'h00 : l2Val[i]);
    end
    check("l2Regs slot3", l2Regs[3], 8'hAB);
    wc(`PPD_IDX_ECR, 8'h80);
    rc(`PPD_IDX_ECR, 8'h81);
    wc(`PPD_IDX_EPPADDR, 8'h12);
    wc(`PPD_IDX_EPP2, 8'h33);
    rc(`PPD_IDX_EPPADDR, 8'h12);
    check("eppTarget", portOut.eppTarget, 8'h12);
    check("mode", portOut.mode, 3'h4);
    rc(`PPD_IDX_EPP2, 8'h35);
    rc(`PPD_IDX_EAR, 8'h80);
    portBase <= 16'h0379;
    rc(`PPD_IDX_EPPADDR, 8'h00);
    rc(`PPD_IDX_EIR, 8'h00);
    portBase <= 16'h0378;
    wc(`PPD_IDX_ECR, 8'h60);
    wc(`PPD_IDX_DATA, 8'h77);
    check("dataLatch", portOut.dataLatch, 8'hA5);
    rc(`PPD_IDX_DATA, 8'h00);
    rc(`PPD_IDX_QUEUE, 8'h77);
    wc(`PPD_IDX_ECR, 8'h40);
    wc(`PPD_IDX_QUEUE, 8'h44);
    rc(`PPD_IDX_QUEUE, 8'h00);
    wc(`PPD_IDX_ECR, 8'hC0);
    rc(`PPD_IDX_QUEUE, 8'h44);
    wc(`PPD_IDX_ECR, 8'hE0);
    rc(`PPD_IDX_QUEUE, 8'h08);
    rc(`PPD_IDX_CFGB, 8'h6B);
    wc(`PPD_IDX_ECR, 8'hA0);
    wc(`PPD_IDX_DATA, 8'h11);
    rc(`PPD_IDX_DATA, 8'h00);
    check("dataLatch", portOut.dataLatch, 8'hA5);
    wr(11'h010, 8'h01, r);
    check("bresp unmapped", r, `PPD_RESP_DECERR);
    rd(11'h010, d, r);
    check("rresp unmapped", r, `PPD_RESP_DECERR);
    finish_test();
  end
endmodule
bind ppd_register_decode ppd_decode_properties u_props (.ref_clk(ref_clk),
  .rst(rst), .ce(ce), .portBase(portBase), .axiReq(axiReq),
  .axiRsp(axiRsp), .sideAcc(sideAcc), .portOut(portOut));
`default_nettype wire
